/* data_mem_pkg.sv */
// Types shared by the data memory space decoder modules
package data_mem_pkg;
    typedef enum logic [2:0] {REGION_REG, REGION_IO, REGION_EXTIO, REGION_SRAM, REGION_EXT,
                              REGION_NONE} region_t;
    typedef enum logic [2:0] {MODE_DIRECT, MODE_DISP, MODE_IND, MODE_PREDEC, MODE_POSTINC} mode_t;
    typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} ptr_sel_t;
    typedef enum logic [1:0] {KIND_DATA, KIND_SHORT_IO, KIND_PC} kind_t;
    typedef enum logic {ST_IDLE, ST_BUSY} state_t;
endpackage

/* data_mem_regs.svh */
// Address map, cycle counts and field constants of the data memory space decoder
`ifndef DATA_MEM_REGS_SVH
`define DATA_MEM_REGS_SVH

// ----------------------------------------------------------------------------
// Address map
// ----------------------------------------------------------------------------
`define DM_IO_BASE 16'h0020
`define DM_EXTIO_BASE 16'h0060
`define DM_SRAM_BASE_NORM 16'h0100
`define DM_INT_END_NORM 16'h0500
`define DM_SRAM_BASE_LEGACY 16'h0060
`define DM_INT_END_LEGACY 16'h0460
`define DM_SRAM_WORDS 1024
`define DM_DISP_MAX 16'h003F
`define DM_PTR_STEP 16'h0001

// ----------------------------------------------------------------------------
// Access cycle counts
// ----------------------------------------------------------------------------
`define DM_BASE_CYCLES 4'h2
`define DM_EXT_EXTRA_WS0 4'h1
`define DM_EXT_EXTRA_WS1 4'h2
`define DM_EXT_EXTRA_WS2 4'h3
`define DM_EXT_EXTRA_WS3 4'h4
`define DM_PC_EXTRA_WS0 4'h3
`define DM_PC_EXTRA_WS1 4'h5
`define DM_PC_EXTRA_WS2 4'h7
`define DM_PC_EXTRA_WS3 4'h9

`endif

/* data_memory_space_decoder.sv */
// Data memory space decoder: region split, internal SRAM and access timing
`timescale 1ns/1ps
`include "data_mem_regs.svh"
module data_memory_space_decoder
    import data_mem_pkg::*;
(
    input wire logic clk, // 100 MHz core clock
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic req_valid, // Access request, held until taken
    input wire logic req_write, // 1 store or push, 0 load or pop
    input wire kind_t req_kind, // Data byte, short I/O port or PC transfer
    input wire mode_t req_mode, // Addressing mode for data accesses
    input wire ptr_sel_t req_ptr, // Pointer pair for indirect modes
    input wire logic [15:0] req_addr, // Direct address, stack address or port
    input wire logic [5:0] req_disp, // Displacement for Y or Z
    input wire logic [15:0] req_wdata, // Store byte in [7:0], PC in [15:0]
    input wire logic [15:0] ptr_x, // Pointer from working registers 26,27
    input wire logic [15:0] ptr_y, // Pointer from working registers 28,29
    input wire logic [15:0] ptr_z, // Pointer from working registers 30,31
    input wire logic legacy_layout, // Legacy-compatible memory layout
    input wire logic ext_mem_enable, // External memory enable of mcu_control_reg
    input wire logic [1:0] wait_states, // External wait states 0..3
    input wire logic [7:0] reg_io_rdata, // Register or I/O read data, same clock
    input wire logic [7:0] ext_data_in, // External data bus, pin level
    output logic req_ready_r, // High while idle, except in reset and the first cycle after it
    output logic done_r, // One-cycle completion pulse
    output logic [15:0] rdata_r, // Read result, valid with done_r; external bytes only at three wait states
    output region_t region_r, // Region of the first byte
    output logic ptr_wb_valid_r, // Pointer write-back pulse
    output ptr_sel_t ptr_wb_sel_r, // Pointer pair to update
    output logic [15:0] ptr_wb_value_r, // New pointer value
    output logic reg_io_rd_r, // Register or I/O read, held to done
    output logic reg_io_wr_r, // Register or I/O write pulse
    output logic [7:0] reg_io_addr_r, // Register or I/O address
    output logic [7:0] reg_io_wdata_r, // Register or I/O write data
    output logic ext_read_strobe_pin, // External read strobe, active high
    output logic ext_write_strobe_pin, // External write strobe, active high
    output logic [15:0] ext_addr_r, // External address
    output logic [7:0] ext_data_out_r, // External data bus drive value
    output logic ext_data_oe_r // External data bus drive enable
);
    // ------------------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------------------
    state_t state_r;
    logic take;
    logic [15:0] ptr_val;
    logic [15:0] addr0;
    logic [15:0] addr1;
    logic [3:0] total;
    logic [3:0] cnt_load;
    dec_if dec_a();
    dec_if dec_b();

    assign take = req_valid && (state_r == ST_IDLE) && req_ready_r; // Nothing taken before ready rises after reset

    // Pointer pairs live in the top six working registers
    assign ptr_val = (req_ptr == PTR_X) ? ptr_x : (req_ptr == PTR_Y) ? ptr_y : ptr_z;

    // Effective address of the first byte; second byte only for PC transfers
    always_comb begin
        addr0 = req_addr;
        case (req_kind)
            KIND_SHORT_IO: addr0 = `DM_IO_BASE + {10'h000, req_addr[5:0]};
            KIND_PC: addr0 = req_addr;
            default: begin
                case (req_mode)
                    MODE_DIRECT: addr0 = req_addr;
                    MODE_DISP: addr0 = (req_ptr == PTR_X) ? ptr_val : ptr_val + {10'h000, req_disp};
                    MODE_PREDEC: addr0 = ptr_val - `DM_PTR_STEP;
                    default: addr0 = ptr_val;
                endcase
            end
        endcase
        addr1 = req_write ? addr0 - `DM_PTR_STEP : addr0 + `DM_PTR_STEP;
    end

    // Two instances of the same decoder: one per byte of a transfer
    assign dec_a.addr = addr0;
    assign dec_a.legacy = legacy_layout;
    assign dec_a.ext_en = ext_mem_enable;
    assign dec_b.addr = addr1;
    assign dec_b.legacy = legacy_layout;
    assign dec_b.ext_en = ext_mem_enable;

    mem_region_decoder u_dec_a (
        .d(dec_a.decoder)
    );

    mem_region_decoder u_dec_b (
        .d(dec_b.decoder)
    );

    // Cycle count of the whole access, decided by the first byte's region
    always_comb begin
        total = `DM_BASE_CYCLES;
        if (dec_a.region == REGION_EXT && req_kind == KIND_PC) begin
            case (wait_states)
                2'h0: total = `DM_BASE_CYCLES + `DM_PC_EXTRA_WS0;
                2'h1: total = `DM_BASE_CYCLES + `DM_PC_EXTRA_WS1;
                2'h2: total = `DM_BASE_CYCLES + `DM_PC_EXTRA_WS2;
                default: total = `DM_BASE_CYCLES + `DM_PC_EXTRA_WS3;
            endcase
        end else if (dec_a.region == REGION_EXT) begin
            case (wait_states)
                2'h0: total = `DM_BASE_CYCLES + `DM_EXT_EXTRA_WS0;
                2'h1: total = `DM_BASE_CYCLES + `DM_EXT_EXTRA_WS1;
                2'h2: total = `DM_BASE_CYCLES + `DM_EXT_EXTRA_WS2;
                default: total = `DM_BASE_CYCLES + `DM_EXT_EXTRA_WS3;
            endcase
        end
        cnt_load = total - 4'h1;
    end

    // ------------------------------------------------------------------------
    // Access sequencing
    // ------------------------------------------------------------------------
    logic [3:0] cnt_r;
    logic [3:0] split_r;
    kind_t kind_r;
    logic write_r;
    logic [15:0] addr1_r;
    region_t region1_r;
    logic [9:0] idx0_r;
    logic [9:0] idx1_r;
    logic [15:0] wdata_r;
    logic [7:0] byte0_r;
    logic final_edge;
    logic split_edge;

    assign final_edge = (state_r == ST_BUSY) && (cnt_r == 4'h1);
    assign split_edge = (state_r == ST_BUSY) && (cnt_r == split_r) && (kind_r == KIND_PC);

    // Busy counter; config is latched at take so a mid-access change is harmless
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            cnt_r <= 4'h0;
            split_r <= 4'h0;
            req_ready_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    req_ready_r <= 1'b1;
                    if (take) begin
                        state_r <= ST_BUSY;
                        cnt_r <= cnt_load;
                        split_r <= (cnt_load >> 1) + 4'h1;
                        req_ready_r <= 1'b0;
                    end
                end
                default: begin
                    if (cnt_r == 4'h1) begin
                        state_r <= ST_IDLE;
                        done_r <= 1'b1;
                        req_ready_r <= 1'b1;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
            endcase
        end
    end

    // Request attributes held for the length of the access
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            kind_r <= KIND_DATA;
            write_r <= 1'b0;
            addr1_r <= 16'h0000;
            region_r <= REGION_REG;
            region1_r <= REGION_REG;
            idx0_r <= 10'h000;
            idx1_r <= 10'h000;
            wdata_r <= 16'h0000;
        end else if (take) begin
            kind_r <= req_kind;
            write_r <= req_write;
            addr1_r <= addr1;
            region_r <= dec_a.region;
            region1_r <= dec_b.region;
            idx0_r <= dec_a.sram_idx;
            idx1_r <= dec_b.sram_idx;
            wdata_r <= req_wdata;
        end
    end

    // Pointer write-back for the auto-stepping modes
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ptr_wb_valid_r <= 1'b0;
            ptr_wb_sel_r <= PTR_X;
            ptr_wb_value_r <= 16'h0000;
        end else begin
            ptr_wb_valid_r <= 1'b0;
            if (take && req_kind == KIND_DATA && (req_mode == MODE_PREDEC || req_mode == MODE_POSTINC)) begin
                ptr_wb_valid_r <= 1'b1;
                ptr_wb_sel_r <= req_ptr;
                ptr_wb_value_r <= (req_mode == MODE_PREDEC) ? ptr_val - `DM_PTR_STEP : ptr_val + `DM_PTR_STEP;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Internal SRAM and read data
    // ------------------------------------------------------------------------
    logic [7:0] sram_mem [0:`DM_SRAM_WORDS-1];
    logic [7:0] ext_s1_r;
    logic [7:0] ext_s2_r;
    logic [7:0] ext_s3_r;
    logic [7:0] ext_in_r;
    logic [7:0] src0;
    logic [7:0] src1;

    // Store bytes land at the end of the access; no reset on the array
    always_ff @(posedge clk) begin
        if (final_edge && write_r && region_r == REGION_SRAM) begin
            sram_mem[idx0_r] <= (kind_r == KIND_PC) ? wdata_r[7:0] : wdata_r[7:0];
        end
        if (final_edge && write_r && kind_r == KIND_PC && region1_r == REGION_SRAM) begin
            sram_mem[idx1_r] <= wdata_r[15:8];
        end
    end

    // Bus pins settle asynchronously; accept a value once two stages agree
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ext_s1_r <= 8'h00;
            ext_s2_r <= 8'h00;
            ext_s3_r <= 8'h00;
            ext_in_r <= 8'h00;
        end else begin
            ext_s1_r <= ext_data_in;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
            if (ext_s2_r == ext_s3_r) begin
                ext_in_r <= ext_s3_r;
            end
        end
    end

    // Byte source by region; a disabled external space reads as zero
    always_comb begin
        case (region_r)
            REGION_SRAM: src0 = sram_mem[idx0_r];
            REGION_EXT: src0 = ext_in_r;
            REGION_NONE: src0 = 8'h00;
            default: src0 = (kind_r == KIND_PC) ? 8'h00 : reg_io_rdata;
        endcase
        case (region1_r)
            REGION_SRAM: src1 = sram_mem[idx1_r];
            REGION_EXT: src1 = ext_in_r;
            default: src1 = 8'h00;
        endcase
    end

    // First byte of a PC pop is kept at the split point, second at the end
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            byte0_r <= 8'h00;
            rdata_r <= 16'h0000;
        end else begin
            if (split_edge) begin
                byte0_r <= src0;
            end
            if (final_edge && !write_r) begin
                rdata_r <= (kind_r == KIND_PC) ? {(split_r == 4'h1) ? src0 : byte0_r, src1} : {8'h00, src0};
            end
        end
    end

    // ------------------------------------------------------------------------
    // Register, I/O and external strobes
    // ------------------------------------------------------------------------
    logic int_rio;
    assign int_rio = (dec_a.region == REGION_REG || dec_a.region == REGION_IO || dec_a.region == REGION_EXTIO);

    // Register and I/O side; PC transfers never use it
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            reg_io_rd_r <= 1'b0;
            reg_io_wr_r <= 1'b0;
            reg_io_addr_r <= 8'h00;
            reg_io_wdata_r <= 8'h00;
        end else begin
            reg_io_wr_r <= 1'b0;
            if (take && int_rio && req_kind != KIND_PC) begin
                reg_io_rd_r <= !req_write;
                reg_io_wr_r <= req_write;
                reg_io_addr_r <= addr0[7:0];
                reg_io_wdata_r <= req_wdata[7:0];
            end else if (final_edge) begin
                reg_io_rd_r <= 1'b0;
            end
        end
    end

    // Strobes follow the byte in flight; internal targets never raise them
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ext_read_strobe_pin <= 1'b0;
            ext_write_strobe_pin <= 1'b0;
            ext_addr_r <= 16'h0000;
            ext_data_out_r <= 8'h00;
            ext_data_oe_r <= 1'b0;
        end else if (take) begin
            ext_read_strobe_pin <= !req_write && dec_a.region == REGION_EXT;
            ext_write_strobe_pin <= req_write && dec_a.region == REGION_EXT;
            ext_data_oe_r <= req_write && dec_a.region == REGION_EXT;
            ext_addr_r <= addr0;
            ext_data_out_r <= req_wdata[7:0];
        end else if (final_edge) begin
            ext_read_strobe_pin <= 1'b0;
            ext_write_strobe_pin <= 1'b0;
            ext_data_oe_r <= 1'b0;
        end else if (split_edge) begin
            ext_read_strobe_pin <= !write_r && region1_r == REGION_EXT;
            ext_write_strobe_pin <= write_r && region1_r == REGION_EXT;
            ext_data_oe_r <= write_r && region1_r == REGION_EXT;
            ext_addr_r <= addr1_r;
            ext_data_out_r <= wdata_r[15:8];
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    chk_int_two_cycles: assert property ((take && dec_a.region == REGION_SRAM) |-> ##1 !done_r ##1 done_r)
        else $error("internal SRAM access not done in two cycles");
    chk_ext_ws0_extra: assert property ((take && req_kind == KIND_DATA && dec_a.region == REGION_EXT
        && wait_states == 2'h0) |-> ##3 done_r)
        else $error("external byte without wait states wrong length");
    chk_ext_ws3_extra: assert property ((take && req_kind == KIND_DATA && dec_a.region == REGION_EXT
        && wait_states == 2'h3) |=> (!done_r)[*5] ##1 done_r)
        else $error("external byte with three wait states wrong length");
    chk_pc_ws0_extra: assert property ((take && req_kind == KIND_PC && dec_a.region == REGION_EXT
        && wait_states == 2'h0) |-> ##5 done_r)
        else $error("external PC transfer without wait states wrong length");
    chk_pc_ws2_extra: assert property ((take && req_kind == KIND_PC && dec_a.region == REGION_EXT
        && wait_states == 2'h2) |-> ##9 done_r)
        else $error("external PC transfer with two wait states wrong length");
    chk_int_no_strobe: assert property ((take && dec_a.region != REGION_EXT && dec_b.region != REGION_EXT)
        |=> (!ext_read_strobe_pin && !ext_write_strobe_pin)[*2])
        else $error("external strobe during internal access");
    chk_disabled_reads_zero: assert property ((take && !req_write && req_kind == KIND_DATA
        && dec_a.region == REGION_NONE) |-> ##2 (done_r && rdata_r == 16'h0000))
        else $error("disabled external space did not read zero");
    chk_postinc_writeback: assert property ((take && req_kind == KIND_DATA && req_mode == MODE_POSTINC)
        |=> ptr_wb_valid_r && ptr_wb_value_r == $past(ptr_val) + `DM_PTR_STEP)
        else $error("post-increment pointer write-back wrong");
    chk_short_io_range: assert property ((take && req_kind == KIND_SHORT_IO) |-> dec_a.region == REGION_IO)
        else $error("short I/O access left the standard I/O area");
    chk_legacy_no_extio: assert property (legacy_layout |-> dec_a.region != REGION_EXTIO)
        else $error("extended I/O decoded in legacy layout");
    chk_disp_bound: assert property ((take && req_kind == KIND_DATA && req_mode == MODE_DISP
        && req_ptr == PTR_Y) |-> (addr0 - ptr_y) <= `DM_DISP_MAX)
        else $error("displacement beyond reach");

    cov_int_read: cover property (take && !req_write && dec_a.region == REGION_SRAM ##2 done_r);
    cov_ext_pc_push: cover property (take && req_write && req_kind == KIND_PC && dec_a.region == REGION_EXT);
    cov_ext_ws3: cover property (take && dec_a.region == REGION_EXT && wait_states == 2'h3);
    cov_predec: cover property (take && req_mode == MODE_PREDEC ##1 ptr_wb_valid_r);
endmodule

/* data_memory_space_decoder_test.sv */
// Self-checking bench of the data memory space decoder
`timescale 1ns/1ps
module data_memory_space_decoder_test;
    import data_mem_pkg::*;
    typedef struct {logic [15:0] rd; logic cr; region_t rg; int t; realtime t0;} note_t;
    logic clk = 0;
    logic reset_n = 0;
    logic req_valid = 0, req_write = 0, legacy_layout = 0, ext_mem_enable = 0;
    kind_t req_kind = KIND_DATA;
    mode_t req_mode = MODE_DIRECT;
    ptr_sel_t req_ptr = PTR_X, ptr_wb_sel_r;
    logic [15:0] req_addr = '0, req_wdata = '0, ptr_x = '0, ptr_y = '0, ptr_z = '0, rdata_r, ptr_wb_value_r, ext_addr_r;
    logic [5:0] req_disp = 6'h3F;
    logic [1:0] wait_states = '0, ws;
    logic [7:0] reg_io_rdata = 8'h5A, ext_data_in, reg_io_addr_r, reg_io_wdata_r, ext_data_out_r;
    logic req_ready_r, done_r, ptr_wb_valid_r, reg_io_rd_r, reg_io_wr_r, ext_read_strobe_pin, ext_write_strobe_pin;
    logic ext_data_oe_r;
    region_t region_r, rg;
    int err_total = 0, n_tests = 0, seed = 8504;
    logic [15:0] pc, d;
    logic [15:0] addrs [12] = '{16'h001F, 16'h0020, 16'h005F, 16'h0060, 16'h00FF, 16'h0100, 16'h045F, 16'h0460,
        16'h04FF, 16'h0500, 16'hFFFF, 16'h8000};
    note_t q[$], m_n;
    data_memory_space_decoder u_data_memory_space_decoder (.clk, .reset_n, .req_valid, .req_write, .req_kind,
        .req_mode, .req_ptr, .req_addr, .req_disp, .req_wdata, .ptr_x, .ptr_y, .ptr_z, .legacy_layout,
        .ext_mem_enable, .wait_states, .reg_io_rdata, .ext_data_in, .req_ready_r, .done_r, .rdata_r, .region_r,
        .ptr_wb_valid_r, .ptr_wb_sel_r, .ptr_wb_value_r, .reg_io_rd_r, .reg_io_wr_r, .reg_io_addr_r, .reg_io_wdata_r,
        .ext_read_strobe_pin, .ext_write_strobe_pin, .ext_addr_r, .ext_data_out_r, .ext_data_oe_r);
    ext_sram_model u_ext_sram_model (.clk, .rd_stb(ext_read_strobe_pin), .wr_stb(ext_write_strobe_pin),
        .oe(ext_data_oe_r), .addr(ext_addr_r), .din(ext_data_out_r), .dout(ext_data_in));
    always #5 clk = ~clk;
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Expected region of a byte address from the memory map
    function automatic region_t exp_rg(input logic [15:0] a, input logic lg, input logic en);
        if (a < 16'h0020) return REGION_REG;
        if (a < 16'h0060) return REGION_IO;
        if (!lg && a < 16'h0100) return REGION_EXTIO;
        if (a < (lg ? 16'h0460 : 16'h0500)) return REGION_SRAM;
        return en ? REGION_EXT : REGION_NONE;
    endfunction
    // Configuration only changes once the block is idle
    task automatic cfg(input logic lg, input logic en, input logic [1:0] w);
        wait (q.size() == 0);
        @(posedge clk);
        legacy_layout <= lg;
        ext_mem_enable <= en;
        wait_states <= w;
    endtask
    // Issue one request, note the expectation at the taking edge
    task automatic acc(input logic w, input kind_t k, input mode_t md, input ptr_sel_t p, input logic [15:0] a,
            input logic [15:0] wd, input logic [15:0] rd, input region_t r, input int t, input logic [15:0] wb);
        int i;
        @(posedge clk);
        req_valid <= 1;
        req_write <= w;
        req_kind <= k;
        req_mode <= md;
        req_ptr <= p;
        req_addr <= a;
        req_wdata <= wd;
        for (i = 0; i < 100; i++) begin
            @(posedge clk);
            if (req_ready_r === 1'b1) break;
        end
        if (i == 100) err_total++;
        q.push_back('{rd, !w, r, t, $realtime});
        req_valid <= 0;
        if (md == MODE_PREDEC || md == MODE_POSTINC) begin
            @(posedge clk);
            chk("ptr_wb_valid", 16'(ptr_wb_valid_r), 16'h0001);
            chk("ptr_wb_value", ptr_wb_value_r, wb);
            chk("ptr_wb_sel", 16'(ptr_wb_sel_r), 16'(p));
        end
    endtask
    // Result watcher: strobes, completion time, region and read data
    always @(posedge clk) begin
        if (ext_read_strobe_pin || ext_write_strobe_pin)
            chk("strobe_region", 16'(q.size() > 0 && q[0].rg == REGION_EXT), 16'h0001);
        if (ext_write_strobe_pin === 1'b1 || ext_data_oe_r === 1'b1)
            chk("ext_oe", 16'(ext_data_oe_r), 16'(ext_write_strobe_pin));
        if (reg_io_rd_r === 1'b1 || reg_io_wr_r === 1'b1)
            chk("rio_region", 16'(q.size() > 0 && q[0].rg inside {REGION_REG, REGION_IO, REGION_EXTIO}), 16'h0001);
        if (done_r === 1'b1) begin
            m_n = q.pop_front();
            chk("region", 16'(region_r), 16'(m_n.rg));
            chk("latency", 16'(int'(($realtime - m_n.t0) / 10.0)), 16'(m_n.t));
            if (m_n.cr) chk("rdata", rdata_r, m_n.rd);
        end
    end
    initial begin
        #500000;
        err_total++;
        stop_test();
    end
    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1;
        repeat (2) @(posedge clk);
        for (int l = 0; l < 4; l++) begin
            foreach (addrs[j]) begin
                ws = 2'($random(seed));
                cfg(l[0], l[1], ws);
                rg = exp_rg(addrs[j], l[0], l[1]);
                acc(1, KIND_DATA, MODE_DIRECT, PTR_X, addrs[j], 16'($random(seed)), 0, rg, rg == REGION_EXT ? 3 + ws : 2, 0);
            end
        end
        cfg(0, 0, 0);
        acc(0, KIND_DATA, MODE_DIRECT, PTR_X, 16'h0500, 0, 16'h0000, REGION_NONE, 2, 0);
        $display("test map done");
        cfg(0, 1, 0);
        d = 16'($random(seed)) & 16'h00FF;
        ptr_y <= 16'h00C1;
        ptr_x <= 16'h0100;
        ptr_z <= 16'h0101;
        acc(1, KIND_DATA, MODE_DISP, PTR_Y, 0, d, 0, REGION_SRAM, 2, 0);
        acc(0, KIND_DATA, MODE_POSTINC, PTR_X, 0, 0, d, REGION_SRAM, 2, 16'h0101);
        acc(0, KIND_DATA, MODE_PREDEC, PTR_Z, 0, 0, d, REGION_SRAM, 2, 16'h0100);
        acc(0, KIND_SHORT_IO, MODE_DIRECT, PTR_X, 16'h003F, 0, 16'h005A, REGION_IO, 2, 0);
        $display("test pointer modes done");
        acc(1, KIND_DATA, MODE_DIRECT, PTR_X, 16'h8000, d, 0, REGION_EXT, 3, 0);
        cfg(0, 1, 3);
        acc(0, KIND_DATA, MODE_DIRECT, PTR_X, 16'h8000, 0, d, REGION_EXT, 6, 0);
        for (int k = 0; k < 4; k++) begin
            pc = 16'($random(seed));
            cfg(0, 1, 2'(k));
            acc(1, KIND_PC, MODE_DIRECT, PTR_X, 16'h9001, pc, 0, REGION_EXT, 5 + 2 * k, 0);
            cfg(0, 1, 3);
            acc(0, KIND_PC, MODE_DIRECT, PTR_X, 16'h9000, 0, pc, REGION_EXT, 11, 0);
        end
        cfg(0, 0, 0);
        $display("test external done");
        stop_test();
    end
endmodule

/* dec_if.sv */
// Carrier between the access controller and one address region decoder
`timescale 1ns/1ps
interface dec_if;
    import data_mem_pkg::*;
    logic [15:0] addr;
    logic legacy;
    logic ext_en;
    region_t region;
    logic [9:0] sram_idx;
    modport user (output addr, output legacy, output ext_en, input region, input sram_idx);
    modport decoder (input addr, input legacy, input ext_en, output region, output sram_idx);
endinterface

/* ext_sram_model.sv */
// Behavioural external SRAM behind the strobe pins
`timescale 1ns/1ps
module ext_sram_model (
    input wire logic clk, // Core clock
    input wire logic rd_stb, // Read strobe, active high
    input wire logic wr_stb, // Write strobe, active high
    input wire logic oe, // Block drives the data bus
    input wire logic [15:0] addr, // Byte address
    input wire logic [7:0] din, // Data from the block
    output logic [7:0] dout // Data bus level seen by the block
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_r = 8'h00;
    // Store while strobed; remember the last byte driven out
    always @(posedge clk) begin
        if (wr_stb && oe) mem[addr] <= din;
        if (rd_stb) last_r <= mem[addr];
    end
    // Released bus never holds its last byte, so late sampling shows up
    assign dout = rd_stb ? mem[addr] : ~last_r;
endmodule

/* mem_region_decoder.sv */
// Combinational split of a 16-bit data address into its memory region
`timescale 1ns/1ps
`include "data_mem_regs.svh"
module mem_region_decoder
    import data_mem_pkg::*;
(
    dec_if.decoder d // Address in, region out
);
    logic [15:0] offs;

    // Region boundaries depend on the layout; external space needs the enable
    always_comb begin
        offs = 16'h0000;
        d.region = REGION_NONE;
        if (d.addr < `DM_IO_BASE) begin
            d.region = REGION_REG;
        end else if (d.addr < `DM_EXTIO_BASE) begin
            d.region = REGION_IO;
        end else if (!d.legacy && d.addr < `DM_SRAM_BASE_NORM) begin
            d.region = REGION_EXTIO;
        end else if (!d.legacy && d.addr < `DM_INT_END_NORM) begin
            d.region = REGION_SRAM;
            offs = d.addr - `DM_SRAM_BASE_NORM;
        end else if (d.legacy && d.addr < `DM_INT_END_LEGACY) begin
            d.region = REGION_SRAM;
            offs = d.addr - `DM_SRAM_BASE_LEGACY;
        end else if (d.ext_en) begin
            d.region = REGION_EXT;
        end else begin
            d.region = REGION_NONE;
        end
        d.sram_idx = offs[9:0];
    end
endmodule
